// file: rtl/boot_remap_address_decoder.sv
// per-master address decoders, per-slave arbiters, boot select, remap and sram split
`timescale 1ns/1ps
`default_nettype none
module boot_remap_address_decoder
(
  input  wire logic        core_clk,                 // system clock
  input  wire logic        sys_rst,                  // sync reset, high
  input  wire logic        boot_source_select,       // boot pin, 1 = rom
  input  wire logic        swap_ctrl_instr_master,   // remap for master 0
  input  wire logic        swap_ctrl_data_master,    // remap for master 1
  input  wire logic        sram_cfg_load,            // load bank sizes, pulse
  input  wire logic [1:0]  sram_a_size,              // bank a size code
  input  wire logic [1:0]  sram_b_size,              // bank b size code
  input  wire logic [1:0]  arb_mode [5],             // per-slave default mode
  input  wire logic [2:0]  arb_fixed_mst [5],        // per-slave fixed master
  input  wire logic [7:0]  arb_slot_limit [5],       // per-slave slot limit
  input  wire logic [4:0]  mst_req,                  // per-master request
  input  wire logic [31:0] mst_addr [5],             // per-master address
  output logic      [2:0]  mst_slave_ff [5],         // decoded slave
  output logic      [4:0]  mst_route_ok_ff,          // decoded to a slave
  output logic      [4:0]  mst_abort_ff,             // abort answer
  output logic      [2:0]  mst_cs_ff [5],            // external chip select
  output logic      [3:0]  mst_sram_blk_ff [5],      // physical sram block
  output logic      [4:0]  mst_done_ff,              // zero-wait completion
  output logic      [4:0]  slv_grant [5],            // per-slave grant
  output logic      [2:0]  slv_owner [5],            // per-slave owner
  output logic      [3:0]  sram_a_blocks_ff,         // bank a blocks
  output logic      [3:0]  sram_b_blocks_ff,         // bank b blocks
  output logic      [3:0]  sram_c_blocks_ff,         // bank c blocks
  output logic             boot_from_rom_ff,         // held boot pin
  output logic             ext_cs0_reset_timing_ff   // chip select 0 boot mode
);
  logic       boot_cap_done_ff;
  logic [3:0] nxt_c_blocks;
  logic [4:0] dec_ok;
  logic [2:0] dec_slave [5];
  logic [2:0] dec_cs [5];
  logic [3:0] dec_blk [5];
  logic [4:0] slv_req [5];
  logic [4:0] nxt_done;

  // k-th free block for bank c, highest block first
  function automatic logic [4:0] c_block(input logic [5:0] k, input logic [3:0] a_blk, input logic [3:0] b_blk);
    logic [4:0] r;
    logic [3:0] n;
    logic [3:0] bb;
    logic       a_used;
    logic       b_used;
    r = 5'h00;
    n = 4'h0;
    bb = 4'h0;
    a_used = 1'b0;
    b_used = 1'b0;
    for (int b = int'(boot_remap_pkg::SRAM_BLOCKS) - 1; b >= 0; b--)
    begin
      bb     = 4'(b);
      a_used = (bb <= boot_remap_pkg::A_TOP_BLOCK) && (bb + a_blk > boot_remap_pkg::A_TOP_BLOCK);
      b_used = (bb > boot_remap_pkg::A_TOP_BLOCK) && (bb <= boot_remap_pkg::B_TOP_BLOCK) &&
               (bb + b_blk > boot_remap_pkg::B_TOP_BLOCK);
      if (!a_used && !b_used)
      begin
        if (({2'h0, n} == k) && !r[4])
          r = {1'b1, bb};
        n = n + 4'h1;
      end
    end
    return r;
  endfunction

  // one address decode: {ok, slave, chip select, block}
  function automatic logic [10:0] decode(input logic [31:0] a, input logic [2:0] mid, input logic remap,
                                         input logic rom_boot, input logic [3:0] a_blk, input logic [3:0] b_blk);
    logic [3:0] rgn;
    logic [7:0] area;
    logic [5:0] k;
    logic [4:0] cb;
    logic       ok;
    logic [2:0] sel;
    logic [2:0] cs;
    logic [3:0] blk;
    rgn  = a[boot_remap_pkg::REG_HI:boot_remap_pkg::REG_LO];
    area = a[boot_remap_pkg::AREA_HI:boot_remap_pkg::AREA_LO];
    k    = a[boot_remap_pkg::BLK_HI:boot_remap_pkg::BLK_LO];
    cb   = c_block(k, a_blk, b_blk);
    ok   = 1'b0;
    sel  = boot_remap_pkg::SLV_SRAM;
    cs   = 3'h0;
    blk  = 4'h0;
    if ((rgn >= boot_remap_pkg::REG_EXT_FIRST) && (rgn <= boot_remap_pkg::REG_EXT_LAST))
    begin
      ok  = 1'b1;
      sel = boot_remap_pkg::SLV_EXT;
      cs  = 3'(rgn - boot_remap_pkg::REG_EXT_FIRST);
    end
    else if (rgn == boot_remap_pkg::REG_PERIPH)
    begin
      ok  = 1'b1;
      sel = boot_remap_pkg::SLV_PERIPH;
    end
    else if (rgn == boot_remap_pkg::REG_INTERNAL)
    begin
      unique case (area)
        boot_remap_pkg::AREA_BOOT:
        begin
          // only the two processor masters see a boot target
          if ((mid == boot_remap_pkg::MST_INSTR) || (mid == boot_remap_pkg::MST_DATA))
          begin
            if (remap)
            begin
              ok  = cb[4];
              blk = cb[3:0];
            end
            else if (rom_boot)
            begin
              ok  = (a[boot_remap_pkg::ROM_HI:boot_remap_pkg::ROM_LO] == 5'h00);
              sel = boot_remap_pkg::SLV_ROM;
            end
            else
            begin
              ok  = 1'b1;
              sel = boot_remap_pkg::SLV_EXT;
              cs  = boot_remap_pkg::CS_BOOT;
            end
          end
        end
        boot_remap_pkg::AREA_BANK_A:
        begin
          ok  = (k < {2'h0, a_blk});
          blk = boot_remap_pkg::A_TOP_BLOCK - k[3:0];
        end
        boot_remap_pkg::AREA_BANK_B:
        begin
          ok  = (k < {2'h0, b_blk});
          blk = boot_remap_pkg::B_TOP_BLOCK - k[3:0];
        end
        boot_remap_pkg::AREA_BANK_C:
        begin
          ok  = cb[4];
          blk = cb[3:0];
        end
        boot_remap_pkg::AREA_ROM:
        begin
          ok  = (a[boot_remap_pkg::ROM_HI:boot_remap_pkg::ROM_LO] == 5'h00);
          sel = boot_remap_pkg::SLV_ROM;
        end
        boot_remap_pkg::AREA_USBH, boot_remap_pkg::AREA_DISP:
        begin
          ok  = 1'b1;
          sel = boot_remap_pkg::SLV_HOSTIF;
        end
        default:
          ok = 1'b0;
      endcase
    end
    return {ok, sel, cs, blk};
  endfunction

  // boot pin caught once at the first edge after reset release
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      boot_cap_done_ff <= 1'b0;
      boot_from_rom_ff <= 1'b0;
    end
    else if (!boot_cap_done_ff)
    begin
      boot_cap_done_ff <= 1'b1;
      boot_from_rom_ff <= boot_source_select;
    end
  end

  // external boot keeps chip select 0 at its reset timing, 16-bit
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      ext_cs0_reset_timing_ff <= 1'b0;
    else if (!boot_cap_done_ff)
      ext_cs0_reset_timing_ff <= !boot_source_select;
  end

  // bank c size is what a and b leave over
  assign nxt_c_blocks = boot_remap_pkg::SRAM_BLOCKS
                      - boot_remap_pkg::size_blocks(sram_a_size)
                      - boot_remap_pkg::size_blocks(sram_b_size);

  // sram partition, all to bank c after reset
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      sram_a_blocks_ff <= boot_remap_pkg::size_blocks(boot_remap_pkg::SIZE_RESET);
      sram_b_blocks_ff <= boot_remap_pkg::size_blocks(boot_remap_pkg::SIZE_RESET);
      sram_c_blocks_ff <= boot_remap_pkg::SRAM_BLOCKS;
    end
    else if (sram_cfg_load)
    begin
      sram_a_blocks_ff <= boot_remap_pkg::size_blocks(sram_a_size);
      sram_b_blocks_ff <= boot_remap_pkg::size_blocks(sram_b_size);
      sram_c_blocks_ff <= nxt_c_blocks;
    end
  end

  // independent decoder for each master
  always_comb
  begin
    for (int m = 0; m < boot_remap_pkg::NUM_MST; m++)
    begin
      {dec_ok[m], dec_slave[m], dec_cs[m], dec_blk[m]} =
        decode(mst_addr[m], 3'(m),
               (3'(m) == boot_remap_pkg::MST_INSTR) ? swap_ctrl_instr_master :
               (3'(m) == boot_remap_pkg::MST_DATA) ? swap_ctrl_data_master : 1'b0,
               boot_from_rom_ff, sram_a_blocks_ff, sram_b_blocks_ff);
    end
  end

  // request vector seen by each slave arbiter
  always_comb
  begin
    for (int s = 0; s < boot_remap_pkg::NUM_SLV; s++)
    begin
      for (int m = 0; m < boot_remap_pkg::NUM_MST; m++)
      begin
        slv_req[s][m] = mst_req[m] && dec_ok[m] && (dec_slave[m] == 3'(s));
      end
    end
  end

  // one arbiter per slave, each with its own setting
  for (genvar s = 0; s < boot_remap_pkg::NUM_SLV; s++)
  begin : g_arb
    slave_arbiter u_arb
    (
      .core_clk   (core_clk),
      .sys_rst    (sys_rst),
      .req        (slv_req[s]),
      .mode       (arb_mode[s]),
      .fixed_mst  (arb_fixed_mst[s]),
      .slot_limit (arb_slot_limit[s]),
      .grant_ff   (slv_grant[s]),
      .owner_ff   (slv_owner[s])
    );
  end

  // granted rom or sram access ends in the same cycle
  always_comb
  begin
    for (int m = 0; m < boot_remap_pkg::NUM_MST; m++)
    begin
      nxt_done[m] = mst_req[m] && dec_ok[m] &&
                    ((dec_slave[m] == boot_remap_pkg::SLV_SRAM) || (dec_slave[m] == boot_remap_pkg::SLV_ROM)) &&
                    slv_grant[dec_slave[m]][m];
    end
  end

  // registered routing answers per master
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      mst_route_ok_ff <= 5'h00;
      mst_abort_ff    <= 5'h00;
      mst_done_ff     <= 5'h00;
      for (int m = 0; m < boot_remap_pkg::NUM_MST; m++)
      begin
        mst_slave_ff[m]    <= 3'h0;
        mst_cs_ff[m]       <= 3'h0;
        mst_sram_blk_ff[m] <= 4'h0;
      end
    end
    else
    begin
      mst_route_ok_ff <= mst_req & dec_ok;
      mst_abort_ff    <= mst_req & ~dec_ok;
      mst_done_ff     <= nxt_done;
      for (int m = 0; m < boot_remap_pkg::NUM_MST; m++)
      begin
        mst_slave_ff[m]    <= dec_slave[m];
        mst_cs_ff[m]       <= dec_cs[m];
        mst_sram_blk_ff[m] <= dec_blk[m];
      end
    end
  end
endmodule
`default_nettype wire

// file: rtl/boot_remap_pkg.sv
// shared constants and types for the boot and remap address decoder
package boot_remap_pkg;
  // master and slave counts, processor master ids
  localparam int         NUM_MST = 5;
  localparam int         NUM_SLV = 5;
  localparam logic [3:0] MST_CNT = 4'h5;
  localparam logic [2:0] MST_INSTR = 3'h0;
  localparam logic [2:0] MST_DATA  = 3'h1;
  // top-level region split: sixteen 256 MB regions
  localparam int         REG_HI = 31;
  localparam int         REG_LO = 28;
  localparam logic [3:0] REG_INTERNAL  = 4'h0;
  localparam logic [3:0] REG_EXT_FIRST = 4'h1;
  localparam logic [3:0] REG_EXT_LAST  = 4'h8;
  localparam logic [3:0] REG_PERIPH    = 4'hF;
  // second stage inside region zero: 1 MB areas
  localparam int         AREA_HI = 27;
  localparam int         AREA_LO = 20;
  localparam logic [7:0] AREA_BOOT   = 8'h00;
  localparam logic [7:0] AREA_BANK_A = 8'h01;
  localparam logic [7:0] AREA_BANK_B = 8'h02;
  localparam logic [7:0] AREA_BANK_C = 8'h03;
  localparam logic [7:0] AREA_ROM    = 8'h04;
  localparam logic [7:0] AREA_USBH   = 8'h05;
  localparam logic [7:0] AREA_DISP   = 8'h06;
  // 16 KB block index and 32 KB rom window
  localparam int         BLK_HI = 19;
  localparam int         BLK_LO = 14;
  localparam int         ROM_HI = 19;
  localparam int         ROM_LO = 15;
  // sram partition: ten blocks, two always in bank c
  localparam logic [3:0] SRAM_BLOCKS    = 4'hA;
  localparam logic [3:0] C_FIXED_BLOCKS = 4'h2;
  localparam logic [3:0] A_TOP_BLOCK    = 4'h3;
  localparam logic [3:0] B_TOP_BLOCK    = 4'h7;
  localparam logic [1:0] SIZE_RESET     = 2'h0;
  localparam logic [2:0] CS_BOOT        = 3'h0;
  localparam int         SLOT_W         = 8;
  // slave numbering
  typedef enum logic [2:0] {SLV_SRAM, SLV_ROM, SLV_HOSTIF, SLV_EXT, SLV_PERIPH} slave_e;
  // default-master modes of an arbiter
  typedef enum logic [1:0] {ARB_NO_DEFAULT, ARB_LAST_DEFAULT, ARB_FIXED_DEFAULT} arb_mode_e;

  // size code to block count: 0, 16, 32, 64 KB
  function automatic logic [3:0] size_blocks(input logic [1:0] code);
    logic [3:0] n;
    n = 4'h0;
    unique case (code)
      2'h0: n = 4'h0;
      2'h1: n = 4'h1;
      2'h2: n = 4'h2;
      2'h3: n = 4'h4;
    endcase
    return n;
  endfunction
endpackage

// file: rtl/slave_arbiter.sv
// round-robin arbiter with default master and slot limit for one slave
`timescale 1ns/1ps
`default_nettype none
module slave_arbiter
(
  input  wire logic        core_clk,     // system clock
  input  wire logic        sys_rst,      // sync reset, high
  input  wire logic [4:0]  req,          // requesting masters
  input  wire logic [1:0]  mode,         // default-master mode
  input  wire logic [2:0]  fixed_mst,    // fixed default master
  input  wire logic [7:0]  slot_limit,   // burst cycles, 0 = none
  output logic      [4:0]  grant_ff,     // one-hot grant
  output logic      [2:0]  owner_ff      // last granted master
);
  logic [7:0] slot_cnt_ff;
  logic [7:0] nxt_slot_cnt;
  logic [4:0] nxt_grant;
  logic [2:0] nxt_owner;
  logic [2:0] pick;
  logic       found;
  logic [3:0] cand;
  logic       expired;
  logic       keep;

  // next requester after the last owner, owner itself last
  always_comb
  begin
    pick  = owner_ff;
    found = 1'b0;
    cand  = 4'h0;
    for (int i = 1; i <= boot_remap_pkg::NUM_MST; i++)
    begin
      cand = 4'(owner_ff) + 4'(i);
      if (cand >= boot_remap_pkg::MST_CNT)
        cand = cand - boot_remap_pkg::MST_CNT;
      if (!found && req[cand[2:0]])
      begin
        pick  = cand[2:0];
        found = 1'b1;
      end
    end
  end

  // slot used up while others wait: break the burst
  assign expired = (slot_limit != 8'h00) && (slot_cnt_ff >= slot_limit - 8'h01);
  assign keep    = (|(grant_ff & req)) && !(expired && (|(req & ~grant_ff)));

  // grant decision and parking
  always_comb
  begin
    nxt_grant    = grant_ff;
    nxt_owner    = owner_ff;
    nxt_slot_cnt = 8'h00;
    if (keep)
    begin
      nxt_slot_cnt = (slot_cnt_ff == 8'hFF) ? slot_cnt_ff : slot_cnt_ff + 8'h01;
    end
    else if (|req)
    begin
      nxt_owner = pick;
      nxt_grant = 5'(5'h01 << pick);
    end
    else
    begin
      unique case (mode)
        boot_remap_pkg::ARB_NO_DEFAULT:
          nxt_grant = 5'h00;
        boot_remap_pkg::ARB_LAST_DEFAULT:
          nxt_grant = 5'(5'h01 << owner_ff);
        boot_remap_pkg::ARB_FIXED_DEFAULT:
        begin
          if (4'(fixed_mst) < boot_remap_pkg::MST_CNT)
          begin
            nxt_owner = fixed_mst;
            nxt_grant = 5'(5'h01 << fixed_mst);
          end
          else
            nxt_grant = 5'h00;
        end
        default:
          nxt_grant = 5'h00;
      endcase
    end
  end

  // arbiter state
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      grant_ff    <= 5'h00;
      owner_ff    <= 3'h0;
      slot_cnt_ff <= 8'h00;
    end
    else
    begin
      grant_ff    <= nxt_grant;
      owner_ff    <= nxt_owner;
      slot_cnt_ff <= nxt_slot_cnt;
    end
  end
endmodule
`default_nettype wire

// file: test/boot_remap_address_decoder_bench.sv
// self-checking bench for the boot and remap address decoder
`timescale 1ns/1ps
`default_nettype none
module boot_remap_address_decoder_bench;
  logic        core_clk, sys_rst, boot_source_select, sram_cfg_load, boot_exp, boot_rom, ext_cs0;
  logic [1:0]  sram_a_size, sram_b_size, swp;
  logic [1:0]  arb_mode [5];
  logic [2:0]  arb_fixed_mst [5];
  logic [7:0]  arb_slot_limit [5];
  logic [7:0]  len;
  logic [4:0]  start, mst_req, route_ok, abort_ff, done;
  logic [31:0] addr_in [5];
  logic [31:0] mst_addr [5];
  logic [31:0] ra;
  logic [2:0]  slave [5];
  logic [2:0]  cs [5];
  logic [2:0]  owner [5];
  logic [3:0]  sblk [5];
  logic [4:0]  grant [5];
  logic [3:0]  a_n, b_n, c_n;
  int          failures, total_checks, an, bn, n, cyc, d2, d3;
  logic [31:0] tbl [14] = '{32'h0, 32'h1000_0000, 32'h8FFF_FFFC, 32'h9000_0000, 32'hE000_0000,
    32'hF000_0000, 32'h0030_0000, 32'h0032_4000, 32'h0032_8000, 32'h0040_7FFC, 32'h0040_8000,
    32'h0010_0000, 32'h0050_0000, 32'h0070_0000};

  // clock
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  master_model masters (.core_clk(core_clk), .sys_rst(sys_rst), .start(start), .addr_in(addr_in),
    .len(len), .mst_req(mst_req), .mst_addr(mst_addr));

  boot_remap_address_decoder dut
  (
    .core_clk(core_clk), .sys_rst(sys_rst), .boot_source_select(boot_source_select),
    .swap_ctrl_instr_master(swp[0]), .swap_ctrl_data_master(swp[1]), .sram_cfg_load(sram_cfg_load),
    .sram_a_size(sram_a_size), .sram_b_size(sram_b_size), .arb_mode(arb_mode),
    .arb_fixed_mst(arb_fixed_mst), .arb_slot_limit(arb_slot_limit), .mst_req(mst_req),
    .mst_addr(mst_addr), .mst_slave_ff(slave), .mst_route_ok_ff(route_ok), .mst_abort_ff(abort_ff),
    .mst_cs_ff(cs), .mst_sram_blk_ff(sblk), .mst_done_ff(done), .slv_grant(grant), .slv_owner(owner),
    .sram_a_blocks_ff(a_n), .sram_b_blocks_ff(b_n), .sram_c_blocks_ff(c_n),
    .boot_from_rom_ff(boot_rom), .ext_cs0_reset_timing_ff(ext_cs0)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t seen %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic close_out;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // expected {abort, ok, slave, select} for one master and address
  function automatic logic [7:0] dec(input int m, input logic [31:0] a);
    logic [7:0] ar;
    int         k;
    ar = a[27:20];
    k = a[19:14];
    if (a[31:28] inside {[4'h1:4'h8]}) return {5'h0B, 3'(a[31:28] - 4'h1)};
    if (a[31:28] == 4'hF) return 8'h60;
    if (a[31:28] != 4'h0) return 8'h80;
    if (ar == 8'h0 && m < 2)
    begin
      if (swp[m]) ar = 8'h3;
      else if (boot_exp) ar = 8'h4;
      else return 8'h58;
    end
    if ((ar == 8'h1 && k < an) || (ar == 8'h2 && k < bn) || (ar == 8'h3 && k < 10 - an - bn)) return 8'h40;
    if (ar == 8'h4 && a[19:15] == 5'h0) return 8'h48;
    if (ar == 8'h5 || ar == 8'h6) return 8'h50;
    return 8'h80;
  endfunction

  // expected physical block: a and b count down, c takes the free ones
  function automatic int blk(input logic [31:0] a);
    int k;
    int c;
    k = a[19:14];
    c = 0;
    if (a[27:20] == 8'h1) return 3 - k;
    if (a[27:20] == 8'h2) return 7 - k;
    for (int i = 9; i >= 0; i--)
      if (!(i <= 3 && i > 3 - an) && !(i >= 4 && i <= 7 && i > 7 - bn))
      begin
        if (c == k) return i;
        c++;
      end
    return 0;
  endfunction

  task automatic acc(input int m, input logic [31:0] a);
    logic [7:0] e;
    @(posedge core_clk);
    start <= 5'h1 << m;
    addr_in[m] <= a;
    len <= 8'h3;
    @(posedge core_clk);
    start <= 5'h0;
    e = dec(m, a);
    @(posedge core_clk);
    #1;
    chk({abort_ff[m], route_ok[m]}, e[7:6]);
    if (e[6]) chk(slave[m], e[5:3]);
    if (e[6] && e[5:3] == 3'h3) chk(cs[m], e[2:0]);
    if (e[6] && e[5:3] == 3'h0) chk(sblk[m], blk(a));
    @(posedge core_clk);
    #1;
    chk(done[m], e[6] && e[5:3] < 3'h2);
  endtask

  task automatic cfg(input logic [1:0] ca, input logic [1:0] cb);
    @(posedge core_clk);
    sram_cfg_load <= 1'b1;
    sram_a_size <= ca;
    sram_b_size <= cb;
    @(posedge core_clk);
    sram_cfg_load <= 1'b0;
    an = (ca == 2'h3) ? 4 : ca;
    bn = (cb == 2'h3) ? 4 : cb;
    #1;
    chk({a_n, b_n, c_n}, {4'(an), 4'(bn), 4'(10 - an - bn)});
  endtask

  task automatic do_reset(input logic pin);
    @(posedge core_clk);
    sys_rst <= 1'b1;
    boot_source_select <= pin;
    swp <= 2'h0;
    @(posedge core_clk);
    sys_rst <= 1'b0;
    #1;
    chk({a_n, b_n, c_n}, 12'h00A);
    chk({abort_ff, route_ok, done}, 15'h0);
    @(posedge core_clk);
    boot_source_select <= ~pin;
    #1;
    boot_exp = pin;
    an = 0;
    bn = 0;
    chk({boot_rom, ext_cs0}, {pin, ~pin});
    repeat (3) @(posedge core_clk);
    #1;
    chk(boot_rom, pin);
  endtask

  // hang guard
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      failures++;
      close_out();
    end
  end

  initial
  begin
    void'($urandom(32'h3ADEF19C));
    sys_rst = 1'b1;
    boot_source_select = 1'b1;
    sram_cfg_load = 1'b0;
    sram_a_size = 2'h0;
    sram_b_size = 2'h0;
    swp = 2'h0;
    start = 5'h0;
    len = 8'h1;
    for (int s = 0; s < 5; s++)
    begin
      arb_mode[s] = 2'($urandom % 3);
      arb_fixed_mst[s] = 3'($urandom % 5);
      arb_slot_limit[s] = 8'h3;
      addr_in[s] = 32'h0;
    end
    do_reset(1'b1);
    // corner addresses on every master
    for (int m = 0; m < 5; m++)
      foreach (tbl[i])
        acc(m, tbl[i]);
    // two masters contend for bank c
    @(posedge core_clk);
    arb_mode[0] <= 2'h0;
    addr_in[2] <= 32'h0030_0000;
    addr_in[3] <= 32'h0030_4000;
    len <= 8'h28;
    start <= 5'h0C;
    @(posedge core_clk);
    start <= 5'h0;
    d2 = 0;
    d3 = 0;
    repeat (30)
    begin
      @(posedge core_clk);
      #1;
      d2 += done[2];
      d3 += done[3];
      chk(done[2] & done[3], 1'b0);
    end
    chk(d2 > 8 && d3 > 8, 1'b1);
    repeat (12) @(posedge core_clk);
    #1;
    chk(grant[0], 5'h0);
    // fixed default then last-accessed default
    @(posedge core_clk);
    arb_mode[0] <= 2'h2;
    arb_fixed_mst[0] <= 3'h4;
    repeat (3) @(posedge core_clk);
    #1;
    chk(grant[0], 5'h10);
    @(posedge core_clk);
    arb_fixed_mst[0] <= 3'h6;
    repeat (2) @(posedge core_clk);
    #1;
    chk(grant[0], 5'h00);
    @(posedge core_clk);
    arb_mode[0] <= 2'h1;
    acc(1, 32'h0030_0000);
    repeat (3) @(posedge core_clk);
    #1;
    chk({grant[0], owner[0]}, {5'h02, 3'h1});
    @(posedge core_clk);
    swp <= 2'h3;
    for (int m = 0; m < 3; m++)
      acc(m, 32'h0000_0040);
    // random traffic with random partitions and swap bits
    for (int i = 0; i < 300; i++)
    begin
      if (i % 40 == 0)
      begin
        cfg(2'($urandom), 2'($urandom));
        @(posedge core_clk);
        swp <= 2'($urandom);
      end
      ra = $urandom;
      if (ra[0]) ra[31:23] = 9'h0;
      ra[19:14] = 6'($urandom % 11);
      acc($urandom % 5, ra);
    end
    // every partition, bank edges
    for (int c = 0; c < 16; c++)
    begin
      cfg(2'(c), 2'(c >> 2));
      for (int ar = 1; ar < 4; ar++)
      begin
        n = (ar == 1) ? an : (ar == 2) ? bn : 10 - an - bn;
        acc(4, {12'(ar), 6'(n), 14'h0});
        if (n > 0) acc(4, {12'(ar), 6'(n - 1), 14'h3FFC});
      end
    end
    do_reset(1'b0);
    acc(0, 32'h0000_0000);
    acc(1, 32'h000F_FFFC);
    acc(2, 32'h0030_0000);
    close_out();
  end
endmodule
`default_nettype wire

// file: test/boot_remap_address_decoder_properties.sv
// checker: assertions on the address decoder top-level ports
`timescale 1ns/1ps
`default_nettype none
module decoder_checker
(
  input wire logic        core_clk,                // clock
  input wire logic        sys_rst,                 // sync reset
  input wire logic        swap_ctrl_instr_master,  // remap m0
  input wire logic [7:0]  arb_slot_limit [5],      // slot limits
  input wire logic [4:0]  mst_req,                 // requests
  input wire logic [31:0] mst_addr [5],            // addresses
  input wire logic [2:0]  mst_slave_ff [5],        // decoded slave
  input wire logic [4:0]  mst_route_ok_ff,         // routed
  input wire logic [4:0]  mst_abort_ff,            // aborts
  input wire logic [2:0]  mst_cs_ff [5],           // chip selects
  input wire logic [4:0]  mst_done_ff,             // completions
  input wire logic [4:0]  slv_grant [5],           // grants
  input wire logic [3:0]  sram_a_blocks_ff,        // bank a
  input wire logic [3:0]  sram_b_blocks_ff,        // bank b
  input wire logic [3:0]  sram_c_blocks_ff,        // bank c
  input wire logic        boot_from_rom_ff,        // held pin
  input wire logic        ext_cs0_reset_timing_ff  // ext boot
);
  logic [7:0] hold_ff;
  logic [4:0] prev_gnt_ff;
  logic [4:0] srv_ff;
  logic [2:0] cs_exp_ff;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // held grant count under contention, served masters, expected select
  always_ff @(posedge core_clk)
  begin
    prev_gnt_ff <= sys_rst ? 5'h0 : slv_grant[0];
    srv_ff <= sys_rst ? 5'h0 : mst_req & (slv_grant[0] | slv_grant[1]);
    cs_exp_ff <= mst_addr[0][30:28] - 3'h1;
    if (sys_rst || slv_grant[0] != prev_gnt_ff || (mst_req & slv_grant[0]) == 5'h0 || (mst_req & ~slv_grant[0]) == 5'h0)
      hold_ff <= 8'h0;
    else if (hold_ff != 8'hFF)
      hold_ff <= hold_ff + 8'h1;
  end
  sequence s_ext_req;
    mst_req[0] && mst_addr[0][31:28] inside {[4'h1:4'h8]};
  endsequence
  sequence s_zero_req;
    mst_req[0] && mst_addr[0][31:15] == 17'h0 && !swap_ctrl_instr_master;
  endsequence
  property p_reset_sizes;
    $past(sys_rst) |-> sram_c_blocks_ff == 4'hA && sram_a_blocks_ff == 4'h0 && sram_b_blocks_ff == 4'h0;
  endproperty
  property p_bank_sum;
    sram_a_blocks_ff + sram_b_blocks_ff + sram_c_blocks_ff == 4'hA && sram_c_blocks_ff >= 4'h2;
  endproperty
  property p_boot_hold;
    !$past(sys_rst) && !$past(sys_rst, 2) |-> $stable(boot_from_rom_ff);
  endproperty
  property p_ext_boot;
    !$past(sys_rst) |-> ext_cs0_reset_timing_ff == !boot_from_rom_ff;
  endproperty
  property p_unused_abort;
    mst_req[1] && mst_addr[1][31:28] inside {[4'h9:4'hE]} |=> mst_abort_ff[1] && !mst_route_ok_ff[1];
  endproperty
  property p_ext_route;
    s_ext_req |=> mst_route_ok_ff[0] && mst_slave_ff[0] == 3'h3 && mst_cs_ff[0] == cs_exp_ff;
  endproperty
  property p_rom_zero;
    s_zero_req |=> mst_route_ok_ff[0] && mst_slave_ff[0] == (boot_from_rom_ff ? 3'h1 : 3'h3);
  endproperty
  property p_done_cause;
    (mst_done_ff & ~srv_ff) == 5'h0;
  endproperty
  property p_grant_onehot;
    $onehot0(slv_grant[0]) && $onehot0(slv_grant[1]);
  endproperty
  property p_slot_break;
    arb_slot_limit[0] != 8'h0 |-> hold_ff <= arb_slot_limit[0] + 8'h1;
  endproperty
  a_reset_sizes: assert property (p_reset_sizes) else $error("bank sizes wrong after reset");
  a_bank_sum: assert property (p_bank_sum) else $error("bank blocks do not total ten");
  a_boot_hold: assert property (p_boot_hold) else $error("held boot pin moved");
  a_ext_boot: assert property (p_ext_boot) else $error("external boot flag wrong");
  a_unused_abort: assert property (p_unused_abort) else $error("unused region not aborted");
  a_ext_route: assert property (p_ext_route) else $error("external region select wrong");
  a_rom_zero: assert property (p_rom_zero) else $error("boot target at zero wrong");
  a_done_cause: assert property (p_done_cause) else $error("completion without grant");
  a_grant_onehot: assert property (p_grant_onehot) else $error("grant not one-hot");
  a_slot_break: assert property (p_slot_break) else $error("burst not broken at slot limit");
endmodule
bind boot_remap_address_decoder decoder_checker chk_u
(
  .core_clk(core_clk), .sys_rst(sys_rst), .swap_ctrl_instr_master(swap_ctrl_instr_master),
  .arb_slot_limit(arb_slot_limit), .mst_req(mst_req), .mst_addr(mst_addr), .mst_slave_ff(mst_slave_ff),
  .mst_route_ok_ff(mst_route_ok_ff), .mst_abort_ff(mst_abort_ff), .mst_cs_ff(mst_cs_ff),
  .mst_done_ff(mst_done_ff), .slv_grant(slv_grant), .sram_a_blocks_ff(sram_a_blocks_ff),
  .sram_b_blocks_ff(sram_b_blocks_ff), .sram_c_blocks_ff(sram_c_blocks_ff),
  .boot_from_rom_ff(boot_from_rom_ff), .ext_cs0_reset_timing_ff(ext_cs0_reset_timing_ff)
);
`default_nettype wire

// file: test/master_model.sv
// five bus masters that hold each request for a set count of cycles
`timescale 1ns/1ps
`default_nettype none
module master_model
(
  input  wire logic        core_clk,     // clock
  input  wire logic        sys_rst,      // sync reset
  input  wire logic [4:0]  start,        // begin a request
  input  wire logic [31:0] addr_in [5],  // address to present
  input  wire logic [7:0]  len,          // cycles to hold
  output logic      [4:0]  mst_req,      // requests
  output logic      [31:0] mst_addr [5]  // addresses
);
  logic [7:0] cnt_ff [5];
  // hold request and address, scramble address lines while idle
  always_ff @(posedge core_clk)
  begin
    for (int m = 0; m < 5; m++)
    begin
      if (sys_rst)
      begin
        mst_req[m] <= 1'b0;
        cnt_ff[m] <= 8'h0;
        mst_addr[m] <= 32'h5A5A_A5A5;
      end
      else if (start[m])
      begin
        mst_req[m] <= 1'b1;
        cnt_ff[m] <= len;
        mst_addr[m] <= addr_in[m];
      end
      else if (cnt_ff[m] > 8'h1)
        cnt_ff[m] <= cnt_ff[m] - 8'h1;
      else
      begin
        mst_req[m] <= 1'b0;
        cnt_ff[m] <= 8'h0;
        mst_addr[m] <= ~mst_addr[m];
      end
    end
  end
endmodule
`default_nettype wire
